// ===== level_select_pkg.sv
package level_select_pkg;
   localparam int unsigned sel_width = 4;
   localparam int unsigned addr_width = 7;
   // Slave address chosen by the strap pin
   localparam logic [6:0] addr_strap_low = 7'h08;
   localparam logic [6:0] addr_strap_high = 7'h09;
   localparam logic [3:0] sel_standby = 4'h0;
   localparam logic [3:0] sel_reset = 4'h0;
   // Codes at or above this pick the upper band
   localparam logic [3:0] sel_high_band_first = 4'h8;
   // Nominal output in millivolts, one entry per code
   localparam int unsigned mv_width = 16;
   localparam logic [15:0] level_mv [16] = '{
      16'h0000, 16'h32c8, 16'h3415, 16'h3563,
      16'h36b0, 16'h37fd, 16'h394b, 16'h3a98,
      16'h46e6, 16'h4833, 16'h4981, 16'h4ace,
      16'h4c1b, 16'h4d69, 16'h4eb6, 16'h5003};
   localparam logic [7:0] reg_first_data = 8'h00;
   localparam logic [7:0] status_reset = 8'h00;
   localparam logic [3:0] bit_count_last = 4'h8;

   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_addr = 3'b001,
      st_addr_ack = 3'b010,
      st_wr = 3'b011,
      st_wr_ack = 3'b100,
      st_rd = 3'b101,
      st_rd_ack = 3'b110
   } slave_state_type;
endpackage : level_select_pkg

// ===== output_voltage_select.sv
module output_voltage_select (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Bus pins, sampled synchronous to clk_in
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Address strap, high selects slave address addr_strap_high
   input wire logic addr_strap_in,
   // Status byte returned on reads
   input wire logic [7:0] status_in,
   // Regulator control
   output logic [level_select_pkg::sel_width-1:0] level_select_out,
   output logic output_enable_out,
   output logic standby_out,
   output logic high_band_out,
   output logic [level_select_pkg::mv_width-1:0] level_mv_out
);
   import level_select_pkg::*;

   slave_state_type state, next_state;
   logic scl_prev, next_scl_prev;
   logic sda_prev, next_sda_prev;
   logic [7:0] shift, next_shift;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [3:0] level, next_level;
   logic [3:0] pending, next_pending;
   logic pending_valid, next_pending_valid;
   logic ack_drive, next_ack_drive;
   logic [7:0] tx, next_tx;
   logic sda_drv, next_sda_drv;
   logic sda_en, next_sda_en;
   logic scl_rise, scl_fall, start_cond, stop_cond;
   logic [6:0] my_addr;
   logic enabled, next_enabled;
   logic in_standby, next_in_standby;
   logic upper_band, next_upper_band;
   logic [mv_width-1:0] nominal_mv, next_nominal_mv;

   function automatic logic is_high_band(input logic [3:0] code);
      return code >= sel_high_band_first;
   endfunction : is_high_band

   function automatic logic is_standby(input logic [3:0] code);
      return code == sel_standby;
   endfunction : is_standby

   always_comb begin
      my_addr = addr_strap_in ? addr_strap_high : addr_strap_low;
   end

   assign scl_rise = scl_in && !scl_prev;
   assign scl_fall = !scl_in && scl_prev;
   assign start_cond = scl_in && scl_prev && sda_prev && !sda_in;
   assign stop_cond = scl_in && scl_prev && !sda_prev && sda_in;

   always_comb begin
      next_state = state;
      next_scl_prev = scl_in;
      next_sda_prev = sda_in;
      next_shift = shift;
      next_bit_cnt = bit_cnt;
      next_level = level;
      next_pending = pending;
      next_pending_valid = pending_valid;
      next_ack_drive = ack_drive;
      next_tx = tx;
      next_sda_drv = sda_drv;
      next_sda_en = sda_en;
      if (start_cond) begin
         next_state = st_addr;
         next_bit_cnt = 4'h0;
         next_sda_en = 1'b0;
         next_pending_valid = 1'b0;
      end else if (stop_cond) begin
         next_state = st_idle;
         next_sda_en = 1'b0;
      end else begin
         case (state)
            st_idle: begin
               next_sda_en = 1'b0;
            end
            st_addr, st_wr: begin
               if (scl_rise) begin
                  next_shift = {shift[6:0], sda_in};
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               if (scl_fall && bit_cnt == bit_count_last) begin
                  if (state == st_addr) begin
                     if (shift[7:1] == my_addr) begin
                        next_state = st_addr_ack;
                        next_sda_en = 1'b1;
                        next_sda_drv = 1'b0;
                        next_tx = status_in;
                     end else begin
                        next_state = st_idle;
                     end
                  end else begin
                     // Hold the code until its ack clock completes
                     next_pending = shift[sel_width-1:0];
                     next_pending_valid = 1'b1;
                     next_state = st_wr_ack;
                     next_sda_en = 1'b1;
                     next_sda_drv = 1'b0;
                  end
               end
            end
            st_addr_ack: begin
               if (scl_fall) begin
                  next_bit_cnt = 4'h0;
                  if (shift[0]) begin
                     next_state = st_rd;
                     next_sda_drv = tx[7];
                     next_sda_en = !tx[7];
                     next_tx = {tx[6:0], 1'b0};
                     next_bit_cnt = 4'h1;
                  end else begin
                     next_state = st_wr;
                     next_sda_en = 1'b0;
                  end
               end
            end
            st_wr_ack: begin
               if (scl_fall) begin
                  if (pending_valid) begin
                     next_level = pending;
                  end
                  next_pending_valid = 1'b0;
                  next_sda_en = 1'b0;
                  next_bit_cnt = 4'h0;
                  next_state = st_wr;
               end
            end
            st_rd: begin
               if (scl_fall) begin
                  if (bit_cnt == bit_count_last) begin
                     next_sda_en = 1'b0;
                     next_state = st_rd_ack;
                  end else begin
                     next_sda_en = !tx[7];
                     next_sda_drv = 1'b0;
                     next_tx = {tx[6:0], 1'b0};
                     next_bit_cnt = bit_cnt + 4'h1;
                  end
               end
            end
            st_rd_ack: begin
               if (scl_rise) begin
                  next_ack_drive = !sda_in;
               end
               if (scl_fall) begin
                  if (ack_drive) begin
                     next_state = st_rd;
                     next_tx = {status_in[6:0], 1'b0};
                     next_sda_en = !status_in[7];
                     next_sda_drv = 1'b0;
                     next_bit_cnt = 4'h1;
                  end else begin
                     next_state = st_idle;
                  end
               end
            end
            default: begin
               next_state = st_idle;
               next_sda_en = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state <= st_idle;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
         shift <= 8'h00;
         bit_cnt <= 4'h0;
         level <= sel_reset;
         pending <= sel_reset;
         pending_valid <= 1'b0;
         ack_drive <= 1'b0;
         tx <= status_reset;
         sda_drv <= 1'b0;
         sda_en <= 1'b0;
      end else begin
         state <= next_state;
         scl_prev <= next_scl_prev;
         sda_prev <= next_sda_prev;
         shift <= next_shift;
         bit_cnt <= next_bit_cnt;
         level <= next_level;
         pending <= next_pending;
         pending_valid <= next_pending_valid;
         ack_drive <= next_ack_drive;
         tx <= next_tx;
         sda_drv <= next_sda_drv;
         sda_en <= next_sda_en;
      end
   end

   // Open drain: only ever drive low
   assign sda_out = 1'b0;
   assign sda_oe_out = sda_en && !sda_drv;

   // Decode from the next code so every output moves with it
   always_comb begin
      next_enabled = !is_standby(next_level);
      next_in_standby = is_standby(next_level);
      next_upper_band = is_high_band(next_level);
      next_nominal_mv = level_mv[next_level];
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         enabled <= !is_standby(sel_reset);
         in_standby <= is_standby(sel_reset);
         upper_band <= is_high_band(sel_reset);
         nominal_mv <= level_mv[sel_reset];
      end else begin
         enabled <= next_enabled;
         in_standby <= next_in_standby;
         upper_band <= next_upper_band;
         nominal_mv <= next_nominal_mv;
      end
   end

   always_comb begin
      level_select_out = level;
      output_enable_out = enabled;
      standby_out = in_standby;
      high_band_out = upper_band;
      level_mv_out = nominal_mv;
   end
endmodule : output_voltage_select

// ===== i2c_master_model.sv
module i2c_master_model (
   // Clock
   input wire logic clk_in,
   // Bus
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic start;
      repeat (4) @(posedge clk_in);
      sda_low_out <= 1'b1;
   endtask : start
   // Data moves only while the clock is low
   task automatic bit_io(input logic d, output logic q);
      repeat (4) @(posedge clk_in);
      scl_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      sda_low_out <= !d;
      repeat (4) @(posedge clk_in);
      scl_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      q = sda_in;
   endtask : bit_io
   // Ninth bit 1 releases for slave ack or master nack, 0 is master ack
   task automatic byte_io(input logic [7:0] b, input logic ninth,
                          output logic [7:0] r, output logic q);
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r[i]);
      end
      bit_io(ninth, q);
   endtask : byte_io
   task automatic stop;
      repeat (4) @(posedge clk_in);
      scl_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      sda_low_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      scl_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      sda_low_out <= 1'b0;
   endtask : stop
endmodule : i2c_master_model

// ===== output_voltage_select_chk.sv
module output_voltage_select_chk
   import level_select_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic [3:0] level_select_out,
   input wire logic output_enable_out,
   input wire logic standby_out,
   input wire logic high_band_out,
   input wire logic [15:0] level_mv_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_level_move;
      $changed(level_select_out);
   endsequence
   a_standby_zero: assert property (
      standby_out == (level_select_out == sel_standby))
      else $error("standby does not follow code zero");
   a_output_off: assert property (
      output_enable_out == (level_select_out != sel_standby))
      else $error("output enable does not follow code");
   a_reset_idle: assert property (
      disable iff (1'b0) sys_rst_in |=> standby_out && !sda_oe_out)
      else $error("reset does not give standby");
   a_band_pick: assert property (
      high_band_out == (level_select_out >= sel_high_band_first))
      else $error("band select wrong");
   a_level_volts: assert property (
      level_mv_out == level_mv[level_select_out])
      else $error("nominal level wrong");
   a_drive_clock_low: assert property (
      $changed(sda_oe_out) |-> !scl_in)
      else $error("data line moved while clock high");
   a_open_drain: assert property (
      sda_oe_out |-> sda_out == 1'b0)
      else $error("data line driven high");
   a_apply_after_ack: assert property (
      s_level_move |-> !scl_in && $past(sda_oe_out, 4))
      else $error("code applied without acknowledge");
endmodule : output_voltage_select_chk

bind output_voltage_select output_voltage_select_chk u_chk (
   .clk_in(clk_in),
   .sys_rst_in(sys_rst_in),
   .scl_in(scl_in),
   .sda_out(sda_out),
   .sda_oe_out(sda_oe_out),
   .level_select_out(level_select_out),
   .output_enable_out(output_enable_out),
   .standby_out(standby_out),
   .high_band_out(high_band_out),
   .level_mv_out(level_mv_out)
);

// ===== tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import level_select_pkg::*;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic addr_strap_in = 1'b0;
   logic [7:0] status_in = 8'h00;
   logic scl_in, sda_low, sda_out, sda_oe_out, output_enable_out;
   logic standby_out, high_band_out;
   logic [3:0] level_select_out, prev, c;
   logic [15:0] level_mv_out;
   int fails = 0;
   int tests_run = 0;
   logic [3:0] notes[$];
   wire sda_in = !sda_low && (sda_oe_out ? sda_out : 1'b1);
   always #2 clk_in = !clk_in;
   output_voltage_select u_output_voltage_select (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe_out(sda_oe_out),
      .addr_strap_in(addr_strap_in),
      .status_in(status_in),
      .level_select_out(level_select_out),
      .output_enable_out(output_enable_out),
      .standby_out(standby_out),
      .high_band_out(high_band_out),
      .level_mv_out(level_mv_out)
   );
   i2c_master_model u_i2c_master_model (.clk_in(clk_in), .sda_in(sda_in),
      .scl_out(scl_in), .sda_low_out(sda_low));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude;
      $display("checks=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   function automatic logic [15:0] exp_mv(input logic [3:0] k);
      if (k == 4'h0) return 16'h0000;
      if (k[3]) return 16'(18150 + ((k - 8) * 1000 + 1) / 3);
      return 16'(13000 + ((k - 1) * 1000 + 1) / 3);
   endfunction : exp_mv
   task automatic send(input logic [7:0] ab, input logic [7:0] b,
                       output logic a1, output logic a2, output logic [7:0] r);
      u_i2c_master_model.start();
      u_i2c_master_model.byte_io(ab, 1'b1, r, a1);
      u_i2c_master_model.byte_io(b, 1'b1, r, a2);
      u_i2c_master_model.stop();
   endtask : send
   // Each applied code is matched against the oldest note
   always @(negedge clk_in) begin
      prev <= level_select_out;
      if (!sys_rst_in && level_select_out !== prev) begin
         c = notes.size() ? notes.pop_front() : prev;
         check(16'(level_select_out), 16'(c));
         check(level_mv_out, exp_mv(c));
         check(16'({output_enable_out, standby_out, high_band_out}),
               16'({c != 4'h0, c == 4'h0, c[3]}));
      end
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      fails++;
      conclude();
   end
   initial begin
      logic a1, a2;
      logic [7:0] r, st;
      void'($urandom(2));
      repeat (3) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(negedge clk_in);
      check(16'({standby_out, output_enable_out, sda_oe_out}),
            16'h0004);
      for (int i = 0; i < 16; i++) begin
         st = 8'($urandom);
         addr_strap_in <= i[0];
         notes.push_back(i == 15 ? 4'h0 : 4'(i + 1));
         send({i[0] ? addr_strap_high : addr_strap_low, 1'b0},
              {st[7:4], notes[$]}, a1, a2, r);
         check(16'(a1), 16'h0000);
         check(16'(a2), 16'h0000);
      end
      send({addr_strap_low, 1'b0}, 8'h05, a1, a2, r);
      check(16'(a1), 16'h0001);
      // Code applied, then cleared by a reset in mid-run
      notes.push_back(4'h9);
      send({addr_strap_high, 1'b0}, 8'h09, a1, a2, r);
      check(16'(a2), 16'h0000);
      sys_rst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(negedge clk_in);
      check(16'({standby_out, output_enable_out, sda_oe_out}),
            16'h0004);
      status_in <= st;
      u_i2c_master_model.start();
      u_i2c_master_model.byte_io({addr_strap_high, 1'b1}, 1'b1, r, a1);
      check(16'(a1), 16'h0000);
      // Master ack asks for a second status byte
      u_i2c_master_model.byte_io(8'hff, 1'b0, r, a2);
      check(16'(r), 16'(st));
      st = 8'($urandom);
      status_in <= st;
      u_i2c_master_model.byte_io(8'hff, 1'b1, r, a2);
      check(16'(r), 16'(st));
      u_i2c_master_model.stop();
      repeat (8) @(posedge clk_in);
      check(16'(notes.size()), 16'h0000);
      conclude();
   end
endmodule : tb_top
